// file: hdl/status_event_pkg.sv
// Constants, bit positions and query codes for the status event register sets.
package status_event_pkg;

   localparam int REG_W = 16;
   localparam int STD_W = 8;
   localparam int SET_COUNT = 4;

   // Register set indices.
   localparam int SET_STD = 0;
   localparam int SET_OPER = 1;
   localparam int SET_MEAS = 2;
   localparam int SET_QUES = 3;

   // Standard event bits.
   localparam int STD_OP_COMPLETE = 0;
   localparam int STD_EMPTY_READ_FAULT = 2;
   localparam int STD_INTERNAL_FAULT = 3;
   localparam int STD_RUN_FAULT = 4;
   localparam int STD_BAD_COMMAND = 5;
   localparam int STD_FRONT_KEY_REQUEST = 6;
   localparam int STD_POWER_CYCLED = 7;

   // Operation bits.
   localparam int OPER_CALIBRATING = 0;
   localparam int OPER_SWEEPING = 3;
   localparam int OPER_BUS_LINK_TRIGGER = 5;
   localparam int OPER_ARM_WAIT = 6;
   localparam int OPER_IDLE = 10;

   // Measurement bits; the five bound failures occupy the lowest bits.
   localparam int MEAS_BOUND_LSB = 0;
   localparam int MEAS_BOUND_COUNT = 5;
   localparam int MEAS_ALL_BOUNDS_PASS = 5;
   localparam int MEAS_NEW_SAMPLE_READY = 6;
   localparam int MEAS_SAMPLE_OVER_RANGE = 7;
   localparam int MEAS_LOG_HAS_TWO = 8;
   localparam int MEAS_LOG_FILLED = 9;
   localparam int MEAS_INTERLOCK = 11;
   localparam int MEAS_HEAT_FAULT = 12;
   localparam int MEAS_SOURCE_CLAMPED = 13;
   localparam int MEAS_COMPLIANCE = 14;

   // Questionable bits.
   localparam int QUES_CAL_INVALID = 8;
   localparam int QUES_CMD_WARNING = 14;

   // Bits that exist in each set; all others read as zero.
   localparam logic [REG_W-1:0] USED_MASK [SET_COUNT] = '{
      16'h00FD, 16'h0469, 16'h7BFF, 16'h4100};

   localparam logic [REG_W-1:0] EVENT_RESET = 16'h0000;
   localparam logic [REG_W-1:0] ENABLE_RESET = 16'h0000;
   localparam int LOG_HAS_TWO_LEVEL = 2;

   typedef enum logic [3:0] {
      Q_STD_EVENT, Q_OPER_EVENT, Q_MEAS_EVENT, Q_QUES_EVENT,
      Q_OPER_COND, Q_MEAS_COND, Q_QUES_COND,
      Q_STD_ENABLE, Q_OPER_ENABLE, Q_MEAS_ENABLE, Q_QUES_ENABLE
   } query_t;

   typedef enum logic {
      OPC_IDLE, OPC_WAIT
   } opc_state_t;

endpackage

// file: hdl/status_event_registers.sv
// Standard, operation, measurement and questionable status register sets.
`timescale 1ns/10ps
`default_nettype none

module status_event_registers #(
   parameter int LOG_DEPTH = 100,
   parameter int LOG_COUNT_W = 12
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Query and enable programming from the command parser.
   input wire logic query_valid_i,
   input wire logic [3:0] query_sel_i,
   output logic [15:0] response_data_o,
   output logic response_valid_o,
   input wire logic enable_write_i,
   input wire logic [1:0] enable_sel_i,
   input wire logic [15:0] enable_data_i,
   input wire logic clear_status_i,
   input wire logic status_preset_i,
   // Standard event sources.
   input wire logic opc_query_i,
   input wire logic ops_pending_i,
   input wire logic talk_read_i,
   input wire logic out_queue_empty_i,
   input wire logic internal_fault_i,
   input wire logic run_fault_i,
   input wire logic syntax_error_i,
   input wire logic unknown_command_i,
   input wire logic trigger_received_i,
   input wire logic message_in_progress_i,
   input wire logic front_key_i,
   // Operation conditions.
   input wire logic calibrating_i,
   input wire logic sweeping_i,
   input wire logic bus_link_trigger_i,
   input wire logic arm_wait_i,
   input wire logic idle_i,
   // Measurement conditions.
   input wire logic [4:0] bound_fail_i,
   input wire logic all_bounds_pass_i,
   input wire logic new_sample_ready_i,
   input wire logic sample_over_range_i,
   input wire logic [LOG_COUNT_W-1:0] log_count_i,
   input wire logic interlock_n_i,
   input wire logic heat_fault_i,
   input wire logic source_clamped_i,
   input wire logic compliance_i,
   // Questionable conditions.
   input wire logic cal_const_bad_i,
   input wire logic cal_success_i,
   input wire logic command_warning_i,
   // Summaries toward the status byte.
   output logic standard_summary_o,
   output logic operation_summary_o,
   output logic measurement_summary_o,
   output logic questionable_summary_o
);

   localparam int W = status_event_pkg::REG_W;
   localparam int N = status_event_pkg::SET_COUNT;
   localparam logic [LOG_COUNT_W-1:0] LOG_TWO =
      LOG_COUNT_W'(status_event_pkg::LOG_HAS_TWO_LEVEL);
   localparam logic [LOG_COUNT_W-1:0] LOG_FULL = LOG_COUNT_W'(LOG_DEPTH);
   // Both log thresholds are inclusive: two samples set one flag, a full log the other.

   logic [W-1:0] event_q [N];
   logic [W-1:0] next_event [N];
   logic [W-1:0] enable_q [N];
   logic [W-1:0] set_vec [N];
   logic [W-1:0] cond_prev [N];
   logic [N-1:0] read_clear;
   logic [N-1:0] summary;

   // Pin synchronisers: the first stage feeds only the second.
   // The interlock stages reset high, the idle level of its pin, so no false condition follows.
   logic key_meta;
   logic key_sync;
   logic key_prev;
   logic lock_meta;
   logic lock_sync;

   logic cal_bad_q;
   logic power_seen_q;
   status_event_pkg::opc_state_t opc_state;
   status_event_pkg::opc_state_t next_opc_state;

   wire query_t_ok = query_valid_i;
   // Codes beyond the last query fall through to the default answer of zero.
   status_event_pkg::query_t qsel;
   assign qsel = status_event_pkg::query_t'(query_sel_i);

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         key_meta <= 1'b0;
         key_sync <= 1'b0;
         key_prev <= 1'b0;
         lock_meta <= 1'b1;
         lock_sync <= 1'b1;
      end else begin
         key_meta <= front_key_i;
         key_sync <= key_meta;
         key_prev <= key_sync;
         lock_meta <= interlock_n_i;
         lock_sync <= lock_meta;
      end
   end

   // Only the press edge counts; a key held down reports once.
   wire key_pressed = key_sync & ~key_prev;

   // Operation-complete is held back until pending operations finish.
   // A query that finds nothing pending sets the bit at once.
   wire opc_done = (opc_state == status_event_pkg::OPC_WAIT) && !ops_pending_i;
   wire opc_now = opc_query_i && !ops_pending_i;
   wire opc_fire = opc_now || opc_done;

   always_comb begin
      next_opc_state = opc_state;
      case (opc_state)
         status_event_pkg::OPC_IDLE: begin
            if (opc_query_i && ops_pending_i) begin
               next_opc_state = status_event_pkg::OPC_WAIT;
            end
         end
         status_event_pkg::OPC_WAIT: begin
            if (!ops_pending_i) begin
               next_opc_state = status_event_pkg::OPC_IDLE;
            end
         end
         default: begin
            next_opc_state = status_event_pkg::OPC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         opc_state <= status_event_pkg::OPC_IDLE;
      end else begin
         opc_state <= next_opc_state;
      end
   end

   // The calibration flag stays up until a calibration succeeds; a new bad
   // constant in the same cycle wins.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cal_bad_q <= 1'b0;
      end else begin
         cal_bad_q <= cal_const_bad_i | (cal_bad_q & ~cal_success_i);
      end
   end

   // Power cycled fires once, in the first cycle after reset release.
   // Reset stands for power-up here, so every reset yields exactly one such event.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         power_seen_q <= 1'b0;
      end else begin
         power_seen_q <= 1'b1;
      end
   end

   wire power_event = ~power_seen_q;
   wire bad_command = syntax_error_i | unknown_command_i
      | (trigger_received_i & message_in_progress_i);
   wire empty_read_fault = talk_read_i & out_queue_empty_i;

   // Standard event sources are events, not conditions. They are gathered in a
   // vector of their own so that each element of the set vector has one driver.
   logic [W-1:0] std_set;

   always_comb begin
      std_set = '0;
      std_set[status_event_pkg::STD_OP_COMPLETE] = opc_fire;
      std_set[status_event_pkg::STD_EMPTY_READ_FAULT] = empty_read_fault;
      std_set[status_event_pkg::STD_INTERNAL_FAULT] = internal_fault_i;
      std_set[status_event_pkg::STD_RUN_FAULT] = run_fault_i;
      std_set[status_event_pkg::STD_BAD_COMMAND] = bad_command;
      std_set[status_event_pkg::STD_FRONT_KEY_REQUEST] = key_pressed;
      std_set[status_event_pkg::STD_POWER_CYCLED] = power_event;
   end

   // Live condition registers of the three other sets.
   logic [W-1:0] cond [N];

   always_comb begin
      cond[status_event_pkg::SET_STD] = '0;
      cond[status_event_pkg::SET_OPER] = '0;
      cond[status_event_pkg::SET_OPER][status_event_pkg::OPER_CALIBRATING] = calibrating_i;
      cond[status_event_pkg::SET_OPER][status_event_pkg::OPER_SWEEPING] = sweeping_i;
      cond[status_event_pkg::SET_OPER][status_event_pkg::OPER_BUS_LINK_TRIGGER] =
         bus_link_trigger_i;
      cond[status_event_pkg::SET_OPER][status_event_pkg::OPER_ARM_WAIT] = arm_wait_i;
      cond[status_event_pkg::SET_OPER][status_event_pkg::OPER_IDLE] = idle_i;
      cond[status_event_pkg::SET_MEAS] = '0;
      cond[status_event_pkg::SET_MEAS][status_event_pkg::MEAS_BOUND_LSB +:
         status_event_pkg::MEAS_BOUND_COUNT] = bound_fail_i;
      cond[status_event_pkg::SET_MEAS][status_event_pkg::MEAS_ALL_BOUNDS_PASS] =
         all_bounds_pass_i;
      cond[status_event_pkg::SET_MEAS][status_event_pkg::MEAS_NEW_SAMPLE_READY] =
         new_sample_ready_i;
      cond[status_event_pkg::SET_MEAS][status_event_pkg::MEAS_SAMPLE_OVER_RANGE] =
         sample_over_range_i;
      cond[status_event_pkg::SET_MEAS][status_event_pkg::MEAS_LOG_HAS_TWO] =
         (log_count_i >= LOG_TWO);
      cond[status_event_pkg::SET_MEAS][status_event_pkg::MEAS_LOG_FILLED] =
         (log_count_i >= LOG_FULL);
      cond[status_event_pkg::SET_MEAS][status_event_pkg::MEAS_INTERLOCK] = ~lock_sync;
      cond[status_event_pkg::SET_MEAS][status_event_pkg::MEAS_HEAT_FAULT] = heat_fault_i;
      cond[status_event_pkg::SET_MEAS][status_event_pkg::MEAS_SOURCE_CLAMPED] =
         source_clamped_i;
      cond[status_event_pkg::SET_MEAS][status_event_pkg::MEAS_COMPLIANCE] = compliance_i;
      cond[status_event_pkg::SET_QUES] = '0;
      cond[status_event_pkg::SET_QUES][status_event_pkg::QUES_CAL_INVALID] = cal_bad_q;
      cond[status_event_pkg::SET_QUES][status_event_pkg::QUES_CMD_WARNING] =
         command_warning_i;
   end

   // Which event register the present query reads, and thereby clears.
   // Only event codes clear; condition and enable reads leave every register intact.
   assign read_clear[status_event_pkg::SET_STD] =
      query_t_ok && (qsel == status_event_pkg::Q_STD_EVENT);
   assign read_clear[status_event_pkg::SET_OPER] =
      query_t_ok && (qsel == status_event_pkg::Q_OPER_EVENT);
   assign read_clear[status_event_pkg::SET_MEAS] =
      query_t_ok && (qsel == status_event_pkg::Q_MEAS_EVENT);
   assign read_clear[status_event_pkg::SET_QUES] =
      query_t_ok && (qsel == status_event_pkg::Q_QUES_EVENT);

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_set
         // Condition sets latch on the rising edge of each condition, so a
         // condition that stays up reports once and not again after a read.
         if (g == status_event_pkg::SET_STD) begin : g_std
            assign set_vec[g] = std_set;
         end else begin : g_cond
            assign set_vec[g] = cond[g] & ~cond_prev[g];
         end
         wire [W-1:0] used_set = set_vec[g] & status_event_pkg::USED_MASK[g];
         wire wipe = read_clear[g] | clear_status_i;
         // A set arriving with the clear wins over it.
         assign next_event[g] = (wipe ? '0 : event_q[g]) | used_set;
         assign summary[g] = |(event_q[g] & enable_q[g]);

         always_ff @(posedge sys_clk_i) begin
            if (reset_i) begin
               event_q[g] <= status_event_pkg::EVENT_RESET;
               cond_prev[g] <= '0;
            end else begin
               event_q[g] <= next_event[g];
               cond_prev[g] <= cond[g];
            end
         end

         // Preset wins over a write in the same cycle; enables keep only the used bits.
         wire en_hit = enable_write_i && (enable_sel_i == 2'(g));
         always_ff @(posedge sys_clk_i) begin
            if (reset_i || status_preset_i) begin
               enable_q[g] <= status_event_pkg::ENABLE_RESET;
            end else if (en_hit) begin
               enable_q[g] <= enable_data_i & status_event_pkg::USED_MASK[g];
            end
         end
      end
   endgenerate

   // Summaries are plain logic on the event and enable flops: they never latch, so a
   // read or a clear drops them in the cycle after the clearing edge.
   assign standard_summary_o = summary[status_event_pkg::SET_STD];
   assign operation_summary_o = summary[status_event_pkg::SET_OPER];
   assign measurement_summary_o = summary[status_event_pkg::SET_MEAS];
   assign questionable_summary_o = summary[status_event_pkg::SET_QUES];

   // Response selection; condition registers are read-only and never cleared.
   logic [W-1:0] next_response;

   always_comb begin
      case (qsel)
         status_event_pkg::Q_STD_EVENT: next_response = event_q[status_event_pkg::SET_STD];
         status_event_pkg::Q_OPER_EVENT: next_response = event_q[status_event_pkg::SET_OPER];
         status_event_pkg::Q_MEAS_EVENT: next_response = event_q[status_event_pkg::SET_MEAS];
         status_event_pkg::Q_QUES_EVENT: next_response = event_q[status_event_pkg::SET_QUES];
         status_event_pkg::Q_OPER_COND: next_response =
            cond[status_event_pkg::SET_OPER] & status_event_pkg::USED_MASK[1];
         status_event_pkg::Q_MEAS_COND: next_response =
            cond[status_event_pkg::SET_MEAS] & status_event_pkg::USED_MASK[2];
         status_event_pkg::Q_QUES_COND: next_response =
            cond[status_event_pkg::SET_QUES] & status_event_pkg::USED_MASK[3];
         status_event_pkg::Q_STD_ENABLE: next_response = enable_q[status_event_pkg::SET_STD];
         status_event_pkg::Q_OPER_ENABLE: next_response = enable_q[status_event_pkg::SET_OPER];
         status_event_pkg::Q_MEAS_ENABLE: next_response = enable_q[status_event_pkg::SET_MEAS];
         status_event_pkg::Q_QUES_ENABLE: next_response = enable_q[status_event_pkg::SET_QUES];
         default: next_response = '0;
      endcase
   end

   // The answer is captured at the edge that takes the query; an event register read
   // here is cleared at that same edge, and the answer holds until the next query.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         response_data_o <= '0;
         response_valid_o <= 1'b0;
      end else begin
         response_valid_o <= query_valid_i;
         if (query_valid_i) begin
            response_data_o <= next_response;
         end
      end
   end

endmodule

`default_nettype wire

// file: tb/bus_controller_model.sv
// Bus controller model that issues status queries and collects the answers.
`timescale 1ns/10ps
`default_nettype none
module bus_controller_model (
   input wire logic sys_clk_i,
   output logic query_valid_o,
   output logic [3:0] query_sel_o,
   input wire logic [15:0] response_data_i,
   input wire logic response_valid_i
);
   initial begin
      query_valid_o = 1'b0;
      query_sel_o = 4'hF;
   end
   // The code is inverted once released, so a late capture gives a wrong answer.
   task automatic ask(input logic [3:0] sel, output logic [15:0] data, output logic valid);
      @(posedge sys_clk_i);
      #1;
      query_valid_o = 1'b1;
      query_sel_o = sel;
      @(posedge sys_clk_i);
      #1;
      query_valid_o = 1'b0;
      query_sel_o = ~sel;
      data = response_data_i;
      valid = response_valid_i;
   endtask
endmodule
`default_nettype wire

// file: tb/status_event_registers_properties.sv
// Checker for the query answer timing, unused bits and summaries.
`timescale 1ns/10ps
`default_nettype none
module status_event_registers_properties (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic query_valid_i,
   input wire logic [3:0] query_sel_i,
   input wire logic [15:0] response_data_o,
   input wire logic response_valid_o,
   input wire logic clear_status_i,
   input wire logic status_preset_i,
   input wire logic calibrating_i,
   input wire logic sweeping_i,
   input wire logic bus_link_trigger_i,
   input wire logic arm_wait_i,
   input wire logic idle_i,
   input wire logic standard_summary_o,
   input wire logic operation_summary_o,
   input wire logic measurement_summary_o,
   input wire logic questionable_summary_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   wire logic any_sum = standard_summary_o | operation_summary_o | measurement_summary_o
      | questionable_summary_o;
   wire logic oper_low = !(calibrating_i | sweeping_i | bus_link_trigger_i | arm_wait_i | idle_i);
   property p_resp_pulse;
      query_valid_i |=> response_valid_o;
   endproperty
   a_resp_pulse: assert property (p_resp_pulse) else $error("no answer after query");
   property p_resp_only;
      !query_valid_i |=> !response_valid_o;
   endproperty
   a_resp_only: assert property (p_resp_only) else $error("answer without query");
   property p_resp_hold;
      !query_valid_i |=> $stable(response_data_o);
   endproperty
   a_resp_hold: assert property (p_resp_hold) else $error("answer changed unasked");
   property p_std_upper;
      query_valid_i && query_sel_i == 4'h0 |=> response_data_o[15:8] == 8'h00;
   endproperty
   a_std_upper: assert property (p_std_upper) else $error("standard upper byte set");
   property p_oper_mask;
      query_valid_i && query_sel_i == 4'h4
         |=> (response_data_o & ~status_event_pkg::USED_MASK[1]) == 16'h0000;
   endproperty
   a_oper_mask: assert property (p_oper_mask) else $error("unused operation bit");
   property p_ques_mask;
      query_valid_i && query_sel_i == 4'h3
         |=> (response_data_o & ~status_event_pkg::USED_MASK[3]) == 16'h0000;
   endproperty
   a_ques_mask: assert property (p_ques_mask) else $error("unused questionable bit");
   property p_clear_oper;
      clear_status_i && oper_low |=> !operation_summary_o;
   endproperty
   a_clear_oper: assert property (p_clear_oper) else $error("summary after clear");
   property p_preset;
      status_preset_i |=> !any_sum [*2];
   endproperty
   a_preset: assert property (p_preset) else $error("summary after preset");
   property p_reset_quiet;
      @(posedge sys_clk_i) disable iff (1'b0) reset_i |=> !any_sum && !response_valid_o;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("output after reset");
   c_oper_read: cover property (query_valid_i && query_sel_i == 4'h1);
   c_clear: cover property (clear_status_i);
   c_summary: cover property (operation_summary_o);
endmodule
bind status_event_registers status_event_registers_properties chk_u (.sys_clk_i, .reset_i,
   .query_valid_i, .query_sel_i, .response_data_o, .response_valid_o, .clear_status_i,
   .status_preset_i, .calibrating_i, .sweeping_i, .bus_link_trigger_i, .arm_wait_i, .idle_i,
   .standard_summary_o, .operation_summary_o, .measurement_summary_o, .questionable_summary_o);
`default_nettype wire

// file: tb/tb_status_event_registers.sv
// Self-checking bench for the status event register sets.
`timescale 1ns/10ps
`default_nettype none
module tb_status_event_registers;
   localparam int DEPTH = 4;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic query_valid, response_valid, enable_write, clear_status, status_preset, interlock_n;
   logic [3:0] query_sel, summary;
   logic [1:0] enable_sel;
   logic [15:0] enable_data, response_data, got;
   logic [10:0] std_in, meas_in;
   logic [4:0] oper;
   logic [2:0] ques;
   logic [11:0] log_count;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   logic [10:0] std_drive [10] = '{11'h001, 11'h00C, 11'h004, 11'h010, 11'h020, 11'h040,
      11'h080, 11'h300, 11'h100, 11'h400};
   logic [7:0] std_exp [10] = '{8'h01, 8'h04, 8'h00, 8'h08, 8'h10, 8'h20, 8'h20, 8'h20, 8'h00,
      8'h40};
   status_event_registers #(.LOG_DEPTH(DEPTH), .LOG_COUNT_W(12)) dut_u (.sys_clk_i(sys_clk),
      .reset_i(reset), .query_valid_i(query_valid), .query_sel_i(query_sel),
      .response_data_o(response_data), .response_valid_o(response_valid),
      .enable_write_i(enable_write), .enable_sel_i(enable_sel), .enable_data_i(enable_data),
      .clear_status_i(clear_status), .status_preset_i(status_preset),
      .opc_query_i(std_in[0]), .ops_pending_i(std_in[1]), .talk_read_i(std_in[2]),
      .out_queue_empty_i(std_in[3]), .internal_fault_i(std_in[4]), .run_fault_i(std_in[5]),
      .syntax_error_i(std_in[6]), .unknown_command_i(std_in[7]),
      .trigger_received_i(std_in[8]), .message_in_progress_i(std_in[9]),
      .front_key_i(std_in[10]), .calibrating_i(oper[0]), .sweeping_i(oper[1]),
      .bus_link_trigger_i(oper[2]), .arm_wait_i(oper[3]), .idle_i(oper[4]),
      .bound_fail_i(meas_in[4:0]), .all_bounds_pass_i(meas_in[5]),
      .new_sample_ready_i(meas_in[6]), .sample_over_range_i(meas_in[7]),
      .log_count_i(log_count), .interlock_n_i(interlock_n), .heat_fault_i(meas_in[8]),
      .source_clamped_i(meas_in[9]), .compliance_i(meas_in[10]), .cal_const_bad_i(ques[0]),
      .cal_success_i(ques[1]), .command_warning_i(ques[2]),
      .standard_summary_o(summary[0]), .operation_summary_o(summary[1]),
      .measurement_summary_o(summary[2]), .questionable_summary_o(summary[3]));
   bus_controller_model ctl_u (.sys_clk_i(sys_clk), .query_valid_o(query_valid),
      .query_sel_o(query_sel), .response_data_i(response_data),
      .response_valid_i(response_valid));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic wrap_up();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic expect_reg(input logic [3:0] sel, input logic [15:0] exp, input string what);
      logic valid;
      ctl_u.ask(sel, got, valid);
      check("answer strobe", {15'h0000, valid}, 16'h0001);
      check(what, got, exp);
   endtask
   task automatic t_power_up();
      tick(2);
      expect_reg(4'h0, 16'h0080, "std after power-up");
      expect_reg(4'h0, 16'h0000, "std after read");
      expect_reg(4'h1, 16'h0000, "oper after power-up");
   endtask
   task automatic t_std_events();
      for (int i = 0; i < 10; i++) begin
         std_in = std_drive[i];
         tick(1);
         std_in = '0;
         tick(4);
         expect_reg(4'h0, {8'h00, std_exp[i]}, "std event");
      end
      std_in = 11'h003;
      tick(1);
      std_in = 11'h002;
      tick(2);
      expect_reg(4'h0, 16'h0000, "opc while pending");
      std_in = '0;
      tick(2);
      expect_reg(4'h0, 16'h0001, "opc after pending");
   endtask
   task automatic t_oper();
      oper = 5'h1F;
      tick(2);
      expect_reg(4'h4, 16'h0469, "oper cond");
      expect_reg(4'h1, 16'h0469, "oper event");
      oper = 5'h0F;
      tick(2);
      expect_reg(4'h4, 16'h0069, "oper cond left idle");
      expect_reg(4'h1, 16'h0000, "oper event no rise");
      oper = 5'h00;
   endtask
   task automatic t_meas();
      log_count = 12'h002;
      tick(2);
      expect_reg(4'h2, 16'h0100, "meas two samples");
      meas_in = 11'h7FF;
      log_count = 12'(DEPTH);
      interlock_n = 1'b0;
      tick(4);
      expect_reg(4'h5, 16'h7BFF, "meas cond");
      expect_reg(4'h2, 16'h7AFF, "meas event");
      meas_in = '0;
      log_count = 12'h000;
      interlock_n = 1'b1;
      tick(4);
   endtask
   task automatic t_ques();
      ques = 3'h5;
      tick(1);
      ques = 3'h0;
      tick(2);
      expect_reg(4'h6, 16'h0100, "ques cond");
      expect_reg(4'h3, 16'h4100, "ques event");
      ques = 3'h2;
      tick(1);
      ques = 3'h0;
      expect_reg(4'h6, 16'h0000, "ques cond after cal");
      expect_reg(4'hF, 16'h0000, "unknown code");
   endtask
   task automatic t_clear_preset();
      enable_write = 1'b1;
      enable_sel = 2'h1;
      enable_data = 16'hFFFF;
      tick(1);
      enable_write = 1'b0;
      expect_reg(4'h8, 16'h0469, "oper enable");
      oper = 5'h02;
      tick(1);
      check("oper summary", {15'h0000, summary[1]}, 16'h0001);
      status_preset = 1'b1;
      tick(1);
      status_preset = 1'b0;
      check("summary after preset", {12'h000, summary}, 16'h0000);
      expect_reg(4'h1, 16'h0008, "oper event kept");
      oper = 5'h03;
      tick(1);
      clear_status = 1'b1;
      tick(1);
      clear_status = 1'b0;
      expect_reg(4'h1, 16'h0000, "oper after clear");
      fork
         expect_reg(4'h1, 16'h0000, "oper read with rise");
         begin
            tick(1);
            oper = 5'h0B;
         end
      join
      expect_reg(4'h1, 16'h0040, "rise kept over read");
      oper = 5'h00;
   endtask
   task automatic t_summary();
      enable_write = 1'b1;
      enable_data = 16'hFFFF;
      for (int s = 0; s < 4; s++) begin
         enable_sel = 2'(s);
         tick(1);
      end
      enable_write = 1'b0;
      expect_reg(4'h7, 16'h00FD, "std enable");
      expect_reg(4'h9, 16'h7BFF, "meas enable");
      expect_reg(4'hA, 16'h4100, "ques enable");
      {std_in, meas_in, oper, ques} = {11'h010, 11'h020, 5'h01, 3'h4};
      tick(1);
      {std_in, oper, ques} = '0;
      check("summaries set", {12'h000, summary}, 16'h000F);
      expect_reg(4'h0, 16'h0008, "std event enabled");
      check("std summary after read", {12'h000, summary}, 16'h000E);
      expect_reg(4'h2, 16'h0020, "meas event enabled");
      check("meas summary after read", {12'h000, summary}, 16'h000A);
      clear_status = 1'b1;
      tick(1);
      clear_status = 1'b0;
      check("summaries after clear", {12'h000, summary}, 16'h0000);
      expect_reg(4'h3, 16'h0000, "ques after clear");
      meas_in = '0;
   endtask
   initial begin
      {enable_write, clear_status, status_preset, enable_sel, enable_data} = '0;
      {std_in, meas_in, oper, ques, log_count} = '0;
      interlock_n = 1'b1;
      tick(5);
      reset = 1'b0;
      t_power_up();
      t_std_events();
      t_oper();
      t_meas();
      t_ques();
      t_clear_preset();
      t_summary();
      wrap_up();
   end
endmodule
`default_nettype wire
